// File: hibs_steer.sv
// Drive bus steering: drive selects, byte transceiver enables, bit-7
// routing, floppy port select and DMA request/acknowledge qualifying.
// Assumes host strobes and decode inputs are synchronous to CLK.
//
// Function
// [RULE1] High enable low only with regblock, 16-bit
// [RULE2] Low enable low with regblock select
// [RULE3] Drive write: drive bit7 from host bit7
// [RULE4] Drive read: forward drive bit7, except 3F7H
// [RULE5] Read of 3F7H returns disk-changed status
// [RULE6] Aux decode: aux select plus low enable
// [RULE7] Regblock decode: select plus low or both
// [RULE8] DMA request gated by enable in legacy mode
// [RULE9] Port select 1 data, 0 status
// [RULE10] Host writes status port only for sleep
// [RULE11] DMA acknowledge acts as data-port select
// [RULE12] Legacy mode: acknowledge qualified by enable bit
// [RULE13] Reset leaves base mode, not legacy mode
// [RULE14] Idle: enables, selects off, bit7 undriven
`timescale 1ns/1ps
module hibs_steer (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic [9:0] HOST_ADDR,
  input  wire logic       HOST_IOR_N,
  input  wire logic       HOST_IOW_N,
  input  wire logic       DEC_REGBLK,
  input  wire logic       DEC_AUX,
  input  wire logic       DATA_16BIT,
  input  wire logic       HOST_DATA_BIT7_IN,
  output logic            HOST_DATA_BIT7_OUT,
  output logic            HOST_DATA_BIT7_OE,
  input  wire logic       DRIVE_SIDE_BIT7_IN,
  output logic            DRIVE_SIDE_BIT7_OUT,
  output logic            DRIVE_SIDE_BIT7_OE,
  output logic            DRIVE_REGBLOCK_SELECT_N,
  output logic            DRIVE_AUX_SELECT_N,
  output logic            DRIVE_LO_BYTE_XCVR_EN_N,
  output logic            DRIVE_HI_BYTE_XCVR_EN_N,
  input  wire logic       DISK_CHANGED_STATUS,
  input  wire logic       SET_LEGACY_MODE,
  input  wire logic       SET_BASE_MODE,
  input  wire logic       DMA_ENABLE_BIT,
  input  wire logic       FLOPPY_CTRL_SELECT,
  input  wire logic       PORT_SELECT_ADDR,
  input  wire logic       FDC_DMA_REQ_IN,
  output logic            FDC_DMA_REQ_OUT,
  output logic            FDC_DMA_REQ_OE,
  input  wire logic       DMA_ACK_N,
  output logic            FDC_DATA_PORT_SEL,
  output logic            FDC_STATUS_PORT_SEL,
  output logic            FDC_SLEEP_WRITE,
  output logic            FIFO_OVERRUN
);

  // ===========================================================
  // Mode state
  logic legacy_mode;
  logic next_legacy_mode;

  always_comb begin
    next_legacy_mode = legacy_mode;
    if (SET_BASE_MODE) begin
      next_legacy_mode = 1'b0;
    end else if (SET_LEGACY_MODE) begin
      next_legacy_mode = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      legacy_mode <= hibs_pkg::MODE_RESET; // RULE13
    end else begin
      legacy_mode <= next_legacy_mode;
    end
  end

  // ===========================================================
  // Request capture through the FIFO
  // The FIFO decouples decode from the registered steering; it drains
  // every cycle, so it only fills if steering is ever held off.
  hibs_pkg::hibs_req_t req_in;
  hibs_pkg::hibs_req_t req_out;
  logic                req_valid;
  logic                in_ready;

  always_comb begin
    req_in.addr   = HOST_ADDR;
    req_in.rd     = !HOST_IOR_N;
    req_in.wr     = !HOST_IOW_N;
    req_in.regblk = DEC_REGBLK;
    req_in.aux    = DEC_AUX;
    req_in.wide   = DATA_16BIT;
  end

  hibs_fifo #(
    .WIDTH ($bits(hibs_pkg::hibs_req_t)),
    .DEPTH (hibs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst       (SYS_RST),
    .in_valid  (1'b1),
    .in_ready  (in_ready),
    .in_data   (req_in),
    .out_valid (req_valid),
    .out_ready (1'b1),
    .out_data  (req_out)
  );

  assign FIFO_OVERRUN = !in_ready;

  // ===========================================================
  // Steering state
  hibs_pkg::hibs_state_t state;
  hibs_pkg::hibs_state_t next_state;
  hibs_pkg::hibs_drv_t   drv;
  hibs_pkg::hibs_drv_t   next_drv;
  logic                  rd_3f7;
  logic                  next_rd_3f7;
  logic                  drive_hit;

  always_comb begin
    drive_hit   = req_valid && (req_out.regblk || req_out.aux);
    next_state  = hibs_pkg::HIBS_IDLE;
    next_rd_3f7 = 1'b0;
    next_drv    = '{regblk_sel: 1'b0, aux_sel: 1'b0,
                    lo_en_n: 1'b1, hi_en_n: 1'b1}; // RULE14
    if (drive_hit && (req_out.rd || req_out.wr)) begin
      next_state = req_out.wr ? hibs_pkg::HIBS_WRITE
                              : hibs_pkg::HIBS_READ;
      next_rd_3f7 = req_out.rd &&
                    (req_out.addr == hibs_pkg::AUX_STATUS_ADDR);
      if (req_out.aux) begin
        next_drv.aux_sel = 1'b1;                        // RULE6
        next_drv.lo_en_n = 1'b0;                        // RULE6
      end else begin
        next_drv.regblk_sel = 1'b1;                     // RULE7
        next_drv.lo_en_n    = 1'b0;                     // RULE2
        next_drv.hi_en_n    = !req_out.wide;            // RULE1
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state  <= hibs_pkg::HIBS_IDLE;
      rd_3f7 <= 1'b0;
      drv    <= '{regblk_sel: 1'b0, aux_sel: 1'b0,
                  lo_en_n: 1'b1, hi_en_n: 1'b1};
    end else begin
      state  <= next_state;
      rd_3f7 <= next_rd_3f7;
      drv    <= next_drv;
    end
  end

  assign DRIVE_REGBLOCK_SELECT_N = !drv.regblk_sel;
  assign DRIVE_AUX_SELECT_N      = !drv.aux_sel;
  assign DRIVE_LO_BYTE_XCVR_EN_N = drv.lo_en_n;
  assign DRIVE_HI_BYTE_XCVR_EN_N = drv.hi_en_n;

  // ===========================================================
  // Bit-7 routing
  always_comb begin
    DRIVE_SIDE_BIT7_OE  = (state == hibs_pkg::HIBS_WRITE); // RULE3
    DRIVE_SIDE_BIT7_OUT = HOST_DATA_BIT7_IN;               // RULE3
    HOST_DATA_BIT7_OE   = (state == hibs_pkg::HIBS_READ);
    HOST_DATA_BIT7_OUT  = rd_3f7 ? DISK_CHANGED_STATUS     // RULE5
                                 : DRIVE_SIDE_BIT7_IN;     // RULE4
  end

  // ===========================================================
  // Floppy port select and DMA qualification
  logic ack_ok;

  always_comb begin
    ack_ok = !DMA_ACK_N && (!legacy_mode || DMA_ENABLE_BIT); // RULE12
    FDC_DATA_PORT_SEL   = (FLOPPY_CTRL_SELECT && PORT_SELECT_ADDR)
                          || ack_ok;                          // RULE11
    FDC_STATUS_PORT_SEL = FLOPPY_CTRL_SELECT && !PORT_SELECT_ADDR
                          && !ack_ok;                         // RULE9
    // A status-port write is only legal as the sleep command
    FDC_SLEEP_WRITE     = FDC_STATUS_PORT_SEL && !HOST_IOW_N; // RULE10
    FDC_DMA_REQ_OE      = !legacy_mode || DMA_ENABLE_BIT;     // RULE8
    FDC_DMA_REQ_OUT     = FDC_DMA_REQ_IN && FDC_DMA_REQ_OE;   // RULE8
  end

  // ===========================================================
  // Assertions
  property p_hi_needs_regblk;
    @(posedge CLK) disable iff (SYS_RST)
    !DRIVE_HI_BYTE_XCVR_EN_N |-> !DRIVE_REGBLOCK_SELECT_N;
  endproperty
  a_hi_needs_regblk: assert property (p_hi_needs_regblk) // RULE1
    else $error("High enable without register block select");

  property p_regblk_lo;
    @(posedge CLK) disable iff (SYS_RST)
    !DRIVE_REGBLOCK_SELECT_N |-> !DRIVE_LO_BYTE_XCVR_EN_N;
  endproperty
  a_regblk_lo: assert property (p_regblk_lo) // RULE2
    else $error("Register block select without low enable");

  property p_write_drive;
    @(posedge CLK) disable iff (SYS_RST)
    (req_valid && req_out.wr && !req_out.rd && drive_hit)
      |=> DRIVE_SIDE_BIT7_OE && !HOST_DATA_BIT7_OE;
  endproperty
  a_write_drive: assert property (p_write_drive) // RULE3
    else $error("Drive write did not drive bit 7");

  property p_read_fwd;
    @(posedge CLK) disable iff (SYS_RST)
    (drive_hit && req_out.rd && !req_out.wr
     && req_out.addr != hibs_pkg::AUX_STATUS_ADDR)
      |=> HOST_DATA_BIT7_OE && !DRIVE_SIDE_BIT7_OE
          && HOST_DATA_BIT7_OUT == DRIVE_SIDE_BIT7_IN;
  endproperty
  a_read_fwd: assert property (p_read_fwd) // RULE4
    else $error("Drive bit 7 not forwarded on read");

  property p_3f7;
    @(posedge CLK) disable iff (SYS_RST)
    (drive_hit && req_out.rd && !req_out.wr
     && req_out.addr == hibs_pkg::AUX_STATUS_ADDR)
      |=> HOST_DATA_BIT7_OUT == DISK_CHANGED_STATUS;
  endproperty
  a_3f7: assert property (p_3f7) // RULE5
    else $error("Disk-changed status missing on 3F7H read");

  property p_aux;
    @(posedge CLK) disable iff (SYS_RST)
    !DRIVE_AUX_SELECT_N |-> !DRIVE_LO_BYTE_XCVR_EN_N
                            && DRIVE_HI_BYTE_XCVR_EN_N;
  endproperty
  a_aux: assert property (p_aux) // RULE6
    else $error("Aux select without low enable alone");

  property p_dmareq;
    @(posedge CLK) disable iff (SYS_RST)
    (legacy_mode && !DMA_ENABLE_BIT) |-> !FDC_DMA_REQ_OE;
  endproperty
  a_dmareq: assert property (p_dmareq) // RULE8
    else $error("DMA request driven while disabled");

  property p_ack_gate;
    @(posedge CLK) disable iff (SYS_RST)
    (legacy_mode && !DMA_ENABLE_BIT && !FLOPPY_CTRL_SELECT)
      |-> !FDC_DATA_PORT_SEL;
  endproperty
  a_ack_gate: assert property (p_ack_gate) // RULE12
    else $error("Unqualified acknowledge selected data port");

  property p_idle;
    @(posedge CLK) disable iff (SYS_RST)
    (state == hibs_pkg::HIBS_IDLE) |-> DRIVE_REGBLOCK_SELECT_N
      && DRIVE_AUX_SELECT_N && !DRIVE_SIDE_BIT7_OE
      && DRIVE_LO_BYTE_XCVR_EN_N && DRIVE_HI_BYTE_XCVR_EN_N;
  endproperty
  a_idle: assert property (p_idle) // RULE14
    else $error("Drive signals active while idle");

endmodule : hibs_steer

// File: hibs_pkg.sv
// Package for the host-port drive bus steering block.
// Assumes one synchronous clock domain; no software-visible registers.
package hibs_pkg;

  // ===========================================================
  // Constants
  localparam logic [9:0] AUX_STATUS_ADDR = 10'h3f7;
  localparam int         FIFO_DEPTH      = 4;
  localparam logic       MODE_RESET      = 1'b0;

  // ===========================================================
  // Types
  typedef enum logic [1:0] {
    HIBS_IDLE,
    HIBS_READ,
    HIBS_WRITE
  } hibs_state_t;

  typedef struct packed {
    logic [9:0] addr;
    logic       rd;
    logic       wr;
    logic       regblk;
    logic       aux;
    logic       wide;
  } hibs_req_t;

  typedef struct packed {
    logic       regblk_sel;
    logic       aux_sel;
    logic       lo_en_n;
    logic       hi_en_n;
  } hibs_drv_t;

endpackage : hibs_pkg

// File: hibs_fifo.sv
// Small synchronous FIFO carrying the host request: address, strobes and decode bits.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module hibs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count  <= next_count;
    end
  end

  // Storage has no reset; empty flag guards reads of stale words
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : hibs_fifo

// File: hibs_far_side.sv
// Far-side drive model: bit-7 lane of the drive seen through its selects.
// Assumes the drive selects are active low and change on the rising edge.
`timescale 1ns/1ps
module hibs_far_side (
  input  wire logic clk,
  input  wire logic dev_oe,
  input  wire logic dev_bit,
  input  wire logic regblk_sel_n,
  input  wire logic aux_sel_n,
  output logic      wire_bit
);
  // ==========================================================
  // Drive data bit
  logic stored;
  logic last;
  logic sel;

  assign sel = !regblk_sel_n || !aux_sel_n;

  initial begin
    stored = 1'b1;
    last   = 1'b0;
  end

  always @(posedge clk) begin
    if (sel && dev_oe) begin
      stored <= dev_bit;
    end
    last <= wire_bit;
  end

  // A released lane toggles so that a stale bit cannot pass for data
  always_comb begin
    if (dev_oe) begin
      wire_bit = dev_bit;
    end else if (sel) begin
      wire_bit = stored;
    end else begin
      wire_bit = !last;
    end
  end
endmodule : hibs_far_side

// File: tb.sv
// Self-checking bench for the drive bus steering block.
// Assumes the package, the FIFO and the steering module are compiled first.
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    hibs_pkg::hibs_drv_t drv;
    logic dout_oe, hout_oe, chk, f3f7;
  } hibs_tb_exp_t;

  logic clk, rst, ior_n, iow_n, dreg, daux, w16, hin, hout, hoe, din, dout;
  logic doe, rsel_n, asel_n, lo_n, hi_n, disk_changed_status, leg, base, dma_enable_bit, fcs, psa;
  logic rqi, rqo, rqoe, ack_n, dps, sps, slp, ovr, mode;
  logic [9:0]   addr;
  int           num_errors;
  int           n_compared;
  hibs_tb_exp_t q[$];
  hibs_tb_exp_t cur;

  hibs_steer uut (
    .CLK(clk), .SYS_RST(rst), .HOST_ADDR(addr), .HOST_IOR_N(ior_n),
    .HOST_IOW_N(iow_n), .DEC_REGBLK(dreg), .DEC_AUX(daux), .DATA_16BIT(w16),
    .HOST_DATA_BIT7_IN(hin), .HOST_DATA_BIT7_OUT(hout),
    .HOST_DATA_BIT7_OE(hoe), .DRIVE_SIDE_BIT7_IN(din),
    .DRIVE_SIDE_BIT7_OUT(dout), .DRIVE_SIDE_BIT7_OE(doe),
    .DRIVE_REGBLOCK_SELECT_N(rsel_n), .DRIVE_AUX_SELECT_N(asel_n),
    .DRIVE_LO_BYTE_XCVR_EN_N(lo_n), .DRIVE_HI_BYTE_XCVR_EN_N(hi_n),
    .DISK_CHANGED_STATUS(disk_changed_status), .SET_LEGACY_MODE(leg), .SET_BASE_MODE(base),
    .DMA_ENABLE_BIT(dma_enable_bit), .FLOPPY_CTRL_SELECT(fcs), .PORT_SELECT_ADDR(psa),
    .FDC_DMA_REQ_IN(rqi), .FDC_DMA_REQ_OUT(rqo), .FDC_DMA_REQ_OE(rqoe),
    .DMA_ACK_N(ack_n), .FDC_DATA_PORT_SEL(dps), .FDC_STATUS_PORT_SEL(sps),
    .FDC_SLEEP_WRITE(slp), .FIFO_OVERRUN(ovr)
  );

  hibs_far_side drive (
    .clk(clk), .dev_oe(doe), .dev_bit(dout), .regblk_sel_n(rsel_n),
    .aux_sel_n(asel_n), .wire_bit(din)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // Comparison and verdict
  task automatic report(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : report

  task automatic cmp_drv(input hibs_pkg::hibs_drv_t got,
                         input hibs_pkg::hibs_drv_t exp);
    report({4'h0, got}, {4'h0, exp});
  endtask : cmp_drv

  task automatic cmp_bit(input logic got, input logic exp);
    report({7'h00, got}, {7'h00, exp});
  endtask : cmp_bit

  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // Drivers: every cycle leaves one note, so the two-edge lag stays aligned
  task automatic tick(input logic r, w, g, x, wd, input logic [9:0] a,
                      input logic hb, c);
    hibs_tb_exp_t e;
    logic         hit;
    @(posedge clk);
    ior_n <= !r;
    iow_n <= !w;
    dreg  <= g;
    daux  <= x;
    w16   <= wd;
    addr  <= a;
    hin   <= hb;
    hit = (r || w) && (g || x);
    e.dout_oe = w && hit;
    e.hout_oe = r && !w && hit;
    e.drv = (hit && x) ? 4'b1001 : hit ? {3'b010, !wd} : 4'b1111;
    e.chk = c;
    e.f3f7 = (a == hibs_pkg::AUX_STATUS_ADDR);
    q.push_back(e);
  endtask : tick

  task automatic idle();
    tick(0, 0, 0, 0, 0, 10'h000, 0, 0);
  endtask : idle

  task automatic op(input logic r, w, g, x, wd, input logic [9:0] a,
                    input logic hb, d);
    for (int i = 0; i < 3; i++) begin
      tick(r, w, g, x, wd, a, hb, i == 0);
      disk_changed_status <= d;
    end
  endtask : op

  task automatic fl(input logic f, p, k, n, rq);
    logic ok;
    idle();
    fcs   <= f;
    psa   <= p;
    ack_n <= k;
    dma_enable_bit <= n;
    rqi   <= rq;
    @(negedge clk);
    ok = !k && (!mode || n);
    cmp_bit(dps, (f && p) || ok);
    cmp_bit(sps, f && !p);
    cmp_bit(slp, f && !p && !iow_n);
    cmp_bit(rqoe, !mode || n);
    if (rqoe === 1'b1) cmp_bit(rqo, rq);
  endtask : fl

  // ==========================================================
  // Monitor: the oldest note matches the outputs two edges later
  always @(negedge clk) begin
    if (!rst && q.size() > 2) begin
      cur = q.pop_front();
      cmp_drv({rsel_n, asel_n, lo_n, hi_n}, cur.drv);
      cmp_bit(doe, cur.dout_oe);
      cmp_bit(hoe, cur.hout_oe);
      cmp_bit(ovr, 1'b0);
      if (cur.chk && cur.dout_oe) cmp_bit(dout, hin);
      if (cur.chk && cur.hout_oe) cmp_bit(hout, cur.f3f7 ? disk_changed_status : din);
    end
  end

  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  initial begin
    logic f;
    logic k;
    {ior_n, iow_n, dreg, daux, w16, hin, disk_changed_status, leg, base} = 9'h180;
    {dma_enable_bit, fcs, psa, rqi, ack_n, mode, addr} = 16'h0800;
    num_errors = 0;
    n_compared = 0;
    rst = 1'b1;
    void'($urandom(68));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    op(0, 1, 1, 0, 1, 10'h1f0, 1, 0);
    op(1, 0, 1, 0, 0, 10'h1f0, 0, 0);
    op(1, 0, 0, 1, 0, hibs_pkg::AUX_STATUS_ADDR, 0, 1);
    op(1, 0, 0, 1, 0, hibs_pkg::AUX_STATUS_ADDR, 1, 0);
    op(0, 1, 0, 1, 1, 10'h3f6, 1, 0);
    op(1, 0, 1, 1, 1, 10'h1f7, 0, 1);
    op(1, 1, 1, 0, 1, 10'h1f0, 0, 0);
    op(0, 1, 0, 0, 1, 10'h1f0, 1, 0);
    repeat (48) begin
      op(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
         1'($urandom), ($urandom % 3 == 0) ? 10'h3f7 : 10'($urandom),
         1'($urandom), 1'($urandom));
    end
    for (int m = 0; m < 2; m++) begin
      idle();
      leg <= m[0];
      idle();
      leg <= 1'b0;
      mode = m[0];
      repeat (24) begin
        f = 1'($urandom);
        k = f ? 1'b1 : 1'($urandom);
        // Status port is only selected here, never written
        fl(f, 1'($urandom), k, 1'($urandom), 1'($urandom));
      end
    end
    idle();
    base <= 1'b1;
    idle();
    base <= 1'b0;
    mode = 1'b0;
    fl(0, 0, 0, 0, 1);
    repeat (3) idle();
    complete_run();
  end
endmodule : tb
